// [verilog/pmc_port_ctrl.sv]
/*
 File holds the per-port operating mode controller with its AXI4-Lite
 register slave.
 Assumes all inputs are synchronous to aclk and that the analog front end
 answers each start pulse with one done pulse carrying its measurement.
*/
`timescale 1ns/1ps

// Summary of operation
// - Mode field selects auto, semi-auto or manual.
// - Mode 00b: no detection, no power.
// - Manual runs one commanded detection, reports status.
// - Manual power on or off anytime.
// - Semi-auto repeats detection, powers on command.
// - Auto powers itself after good detection, class.
// - Only auto loads thresholds from class.
// - Auto via strap at reset or 11b write.
// - Any fault removes power in every mode.
// - Disconnect removes power when enabled; host too.
// - Reset from pin or global reset bit.
// - Strap sampled only during reset.
// - Strapped auto: detect, classify, power, unpower.
// - Single-signature table, classes 1 to 8.
// - Dual-signature table, classes 1 to 5.
// - Dual port power cut sums powered channels.
// - Connection check compares two first-channel currents.
// - Attach or detach during check gives invalid.
// - Four-pair detection starts with check unless legacy.
// - Two-pair skips check, reports single signature.
// - Accept 17k to 29k, reject outside 15k-33k.
// - Semi-auto pauses 100 ms between detections.
// - Power-on needs good detection, else start fault.
module pmc_port_ctrl
   import pmc_pkg::*;
#(
   parameter int unsigned HOLD_CYCLES = `PMC_HOLD_MS * `PMC_CLK_KHZ,
   parameter logic [11:0] CC_TOL = 12'h010,
   parameter logic [11:0] CC_MIN = 12'h004
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic auto_strap_pin,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic cc_start,
   input wire logic cc_done,
   input wire logic cc_event,
   input wire logic [11:0] cc_i1,
   input wire logic [11:0] cc_i2,
   output logic det_start,
   input wire logic det_done,
   input wire logic [15:0] det_res_ohm,
   output logic cls_start,
   input wire logic cls_done,
   input wire logic [3:0] cls_result,
   input wire logic [1:0] fault_in,
   input wire logic [1:0] disc_in,
   output logic power_a_en,
   output logic power_b_en,
   output logic [15:0] channel_cut_current,
   output logic [15:0] channel_limit_current,
   output logic [15:0] port_cut_power,
   output logic [15:0] channel_cut_power
);

   if (HOLD_CYCLES < 1 || CC_MIN == 12'h000) begin : g_bad_param
      $error("pmc_port_ctrl: HOLD_CYCLES and CC_MIN must be nonzero");
   end

   pmc_regs_type r;
   pmc_regs_type n;
   logic [3:0] cmd;
   logic clr_fault;
   logic launch;
   logic fin;
   logic dual;
   logic [1:0] ch_off;
   logic [31:0] wv;
   logic [47:0] thr;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = val[i*8 +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic class_ok(input logic [3:0] c, input logic is_dual);
      return (c != 4'h0) && (c <= (is_dual ? `PMC_MAX_CLASS_DUAL : `PMC_MAX_CLASS_SINGLE));
   endfunction

   // Returns {cut current, limit current, power cut} for a valid class.
   function automatic logic [47:0] lookup(input logic [3:0] c, input logic is_dual);
      logic [47:0] res;
      res = '0;
      if (is_dual) begin
         if (class_ok(c, 1'b1)) begin
            res = {PMC_DS_CUT[c], PMC_DS_LIM[c], PMC_DS_PW[c]};
         end
      end else begin
         if (class_ok(c, 1'b0)) begin
            res = {PMC_SS_CUT[c], PMC_SS_LIM[c], PMC_SS_PW[c]};
         end
      end
      return res;
   endfunction

   // The strap is read only here, at reset time. Afterwards it is ignored.
   function automatic pmc_regs_type reset_val(input logic strap);
      pmc_regs_type v;
      v = '0;
      v.strap = strap;
      v.ctrl_mode = strap ? `PMC_MODE_AUTO : `PMC_MODE_OFF;
      v.det_en = strap;
      v.cls_en = strap;
      v.disc_en = strap;
      v.four_pair = `PMC_RST_CTRL_FOUR_PAIR;
      v.cut = `PMC_RST_CUT;
      v.lim = `PMC_RST_LIM;
      v.chpw = `PMC_RST_CHPW;
      v.portpw = `PMC_RST_PORTPW;
      v.awready = 1'b1;
      v.wready = 1'b1;
      v.arready = 1'b1;
      return v;
   endfunction

   function automatic logic [31:0] ctrl_word(input pmc_regs_type s);
      logic [31:0] w;
      w = '0;
      w[`PMC_CTRL_MODE_LSB +: 2] = s.ctrl_mode;
      w[`PMC_CTRL_DET_EN] = s.det_en;
      w[`PMC_CTRL_CLS_EN] = s.cls_en;
      w[`PMC_CTRL_DISC_EN] = s.disc_en;
      w[`PMC_CTRL_FOUR_PAIR] = s.four_pair;
      w[`PMC_CTRL_AT_MODE] = s.at_mode;
      w[`PMC_CTRL_STRAP] = s.strap;
      return w;
   endfunction

   always_comb begin
      n = r;
      cmd = '0;
      clr_fault = 1'b0;
      launch = 1'b0;
      fin = 1'b0;
      wv = '0;
      thr = '0;
      n.cc_start = 1'b0;
      n.det_start = 1'b0;
      n.cls_start = 1'b0;

      // Write address and data are taken independently; the answer waits for both.
      if (r.awready && s_axi_awvalid) begin
         n.awready = 1'b0;
         n.have_aw = 1'b1;
         n.waddr = s_axi_awaddr;
      end
      if (r.wready && s_axi_wvalid) begin
         n.wready = 1'b0;
         n.have_w = 1'b1;
         n.wdata = s_axi_wdata;
         n.wstrb = s_axi_wstrb;
      end
      if (r.have_aw && r.have_w && !r.bvalid) begin
         n.have_aw = 1'b0;
         n.have_w = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = `PMC_RESP_OKAY;
         case (r.waddr)
            `PMC_OFF_CTRL: begin
               wv = merge(ctrl_word(r), r.wdata, r.wstrb);
               n.ctrl_mode = wv[`PMC_CTRL_MODE_LSB +: 2];
               n.det_en = wv[`PMC_CTRL_DET_EN];
               n.cls_en = wv[`PMC_CTRL_CLS_EN];
               n.disc_en = wv[`PMC_CTRL_DISC_EN];
               n.four_pair = wv[`PMC_CTRL_FOUR_PAIR];
               n.at_mode = wv[`PMC_CTRL_AT_MODE];
               n.soft_rst = wv[`PMC_CTRL_GLOBAL_RST];
            end
            `PMC_OFF_CMD: begin
               wv = merge('0, r.wdata, r.wstrb);
               cmd = wv[3:0];
            end
            `PMC_OFF_STAT: begin
               wv = merge('0, r.wdata, r.wstrb);
               clr_fault = wv[`PMC_STAT_START_FAULT];
            end
            `PMC_OFF_CURR: begin
               wv = merge({r.lim, r.cut}, r.wdata, r.wstrb);
               n.cut = wv[15:0];
               n.lim = wv[31:16];
            end
            `PMC_OFF_POWER: begin
               wv = merge({r.chpw, r.portpw}, r.wdata, r.wstrb);
               n.portpw = wv[15:0];
               n.chpw = wv[31:16];
            end
            default: begin
               n.bresp = `PMC_RESP_SLVERR;
            end
         endcase
      end
      if (r.bvalid && s_axi_bready) begin
         n.bvalid = 1'b0;
         n.awready = 1'b1;
         n.wready = 1'b1;
      end

      if (r.arready && s_axi_arvalid) begin
         n.arready = 1'b0;
         n.rvalid = 1'b1;
         n.rresp = `PMC_RESP_OKAY;
         n.rdata = '0;
         case (s_axi_araddr)
            `PMC_OFF_CTRL: n.rdata = ctrl_word(r);
            `PMC_OFF_CMD: n.rdata = '0;
            `PMC_OFF_STAT: begin
               n.rdata[`PMC_STAT_DET_LSB +: 2] = r.det_res;
               n.rdata[`PMC_STAT_CLS_LSB +: 4] = r.cls_res;
               n.rdata[`PMC_STAT_CONN_LSB +: 2] = r.conn;
               n.rdata[`PMC_STAT_PWR_A] = r.pwr_a;
               n.rdata[`PMC_STAT_PWR_B] = r.pwr_b;
               n.rdata[`PMC_STAT_START_FAULT] = r.start_fault;
               n.rdata[`PMC_STAT_STATE_LSB +: 3] = r.state;
            end
            `PMC_OFF_CURR: n.rdata = {r.lim, r.cut};
            `PMC_OFF_POWER: n.rdata = {r.chpw, r.portpw};
            default: n.rresp = `PMC_RESP_SLVERR;
         endcase
      end
      if (r.rvalid && s_axi_rready) begin
         n.rvalid = 1'b0;
         n.arready = 1'b1;
      end

      if (clr_fault) begin
         n.start_fault = 1'b0;
      end

      case (r.state)
         PMC_IDLE: begin
            n.mode_act = r.ctrl_mode;
            if (r.ctrl_mode == `PMC_MODE_MANUAL) begin
               if (cmd[`PMC_CMD_DET] || cmd[`PMC_CMD_DET_CLS]) begin
                  launch = 1'b1;
                  n.cls_want = cmd[`PMC_CMD_DET_CLS];
               end
            end else if (r.ctrl_mode[1] && r.det_en) begin
               launch = 1'b1;
               n.cls_want = r.cls_en;
            end
            if (launch) begin
               n.det_res = DET_UNKNOWN;
               n.cls_res = 4'h0;
               if (r.four_pair && !r.at_mode) begin
                  n.state = PMC_CC;
                  n.cc_start = 1'b1;
                  n.conn = CONN_NONE;
               end else begin
                  n.state = PMC_DET;
                  n.det_start = 1'b1;
                  n.conn = CONN_SINGLE;
               end
            end
         end
         PMC_CC: begin
            if (cc_done) begin
               // A second reading pulled down by the aggressor more than CC_TOL below the first means one shared signature.
               if (cc_event || cc_i1 < CC_MIN) begin
                  n.conn = CONN_INVALID;
                  fin = 1'b1;
               end else begin
                  if ({1'b0, cc_i1} > {1'b0, cc_i2} + {1'b0, CC_TOL}) begin
                     n.conn = CONN_SINGLE;
                  end else begin
                     n.conn = CONN_DUAL;
                  end
                  n.state = PMC_DET;
                  n.det_start = 1'b1;
               end
            end
         end
         PMC_DET: begin
            if (det_done) begin
               if (det_res_ohm < `PMC_RES_ACCEPT_LO) begin
                  n.det_res = DET_LOW;
               end else if (det_res_ohm > `PMC_RES_ACCEPT_HI) begin
                  n.det_res = DET_HIGH;
               end else begin
                  n.det_res = DET_GOOD;
               end
               if (n.det_res == DET_GOOD && r.cls_want) begin
                  n.state = PMC_CLS;
                  n.cls_start = 1'b1;
               end else begin
                  fin = 1'b1;
               end
            end
         end
         PMC_CLS: begin
            if (cls_done) begin
               n.cls_res = cls_result;
               fin = 1'b1;
            end
         end
         PMC_WAIT: begin
            n.hold = r.hold + 32'h0000_0001;
            if (r.hold >= HOLD_CYCLES - 1) begin
               n.state = PMC_IDLE;
            end
         end
         PMC_ON: ;
         default: begin
            n.state = PMC_IDLE;
         end
      endcase

      if (fin) begin
         dual = (n.conn == CONN_DUAL);
         if (r.mode_act == `PMC_MODE_AUTO && n.det_res == DET_GOOD
             && class_ok(n.cls_res, dual)) begin
            thr = lookup(n.cls_res, dual);
            n.cut = thr[47:32];
            n.lim = thr[31:16];
            if (dual) begin
               n.chpw = thr[15:0];
            end else begin
               n.portpw = thr[15:0];
            end
            n.pwr_a = 1'b1;
            n.pwr_b = r.four_pair;
            n.state = PMC_ON;
         end else if (r.mode_act == `PMC_MODE_MANUAL) begin
            n.state = PMC_IDLE;
         end else begin
            n.state = PMC_WAIT;
            n.hold = '0;
         end
      end else begin
         dual = (r.conn == CONN_DUAL);
      end

      // A host power-on preempts a cycle in progress once its detection result is good.
      if (cmd[`PMC_CMD_PWR_ON] && r.ctrl_mode != `PMC_MODE_OFF) begin
         if (r.det_res == DET_GOOD) begin
            n.pwr_a = 1'b1;
            n.pwr_b = r.four_pair;
            n.state = PMC_ON;
         end else begin
            n.start_fault = 1'b1;
         end
      end

      // Removal wins over any power-on in the same cycle for safety.
      ch_off = fault_in | (r.disc_en ? disc_in : 2'h0);
      if (!dual && ch_off != 2'h0) begin
         ch_off = 2'h3;
      end
      if (cmd[`PMC_CMD_PWR_OFF]) begin
         ch_off = 2'h3;
      end
      if (ch_off[0]) begin
         n.pwr_a = 1'b0;
      end
      if (ch_off[1]) begin
         n.pwr_b = 1'b0;
      end
      if (n.state == PMC_ON && !n.pwr_a && !n.pwr_b) begin
         n.state = PMC_IDLE;
      end

      if (dual) begin
         n.portpw = (n.pwr_a ? n.chpw : 16'h0000) + (n.pwr_b ? n.chpw : 16'h0000);
      end

      // Shutdown is applied at once, since leaving a port powered is the hazard.
      if (r.ctrl_mode == `PMC_MODE_OFF) begin
         n.pwr_a = 1'b0;
         n.pwr_b = 1'b0;
         n.state = PMC_IDLE;
         n.cc_start = 1'b0;
         n.det_start = 1'b0;
         n.cls_start = 1'b0;
      end

      // The global reset keeps the bus handshake so the pending answer completes.
      if (r.soft_rst) begin
         n = reset_val(auto_strap_pin);
         n.awready = r.awready || (r.bvalid && s_axi_bready);
         n.wready = r.wready || (r.bvalid && s_axi_bready);
         n.bvalid = r.bvalid && !s_axi_bready;
         n.bresp = r.bresp;
         n.arready = r.arready ? !s_axi_arvalid : (r.rvalid && s_axi_rready);
         n.rvalid = r.rvalid ? !s_axi_rready : (r.arready && s_axi_arvalid);
         n.rdata = (r.arready && s_axi_arvalid) ? '0 : r.rdata;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r <= reset_val(auto_strap_pin);
      end else begin
         r <= n;
      end
   end

   assign s_axi_awready = r.awready;
   assign s_axi_wready = r.wready;
   assign s_axi_bresp = r.bresp;
   assign s_axi_bvalid = r.bvalid;
   assign s_axi_arready = r.arready;
   assign s_axi_rdata = r.rdata;
   assign s_axi_rresp = r.rresp;
   assign s_axi_rvalid = r.rvalid;
   assign cc_start = r.cc_start;
   assign det_start = r.det_start;
   assign cls_start = r.cls_start;
   assign power_a_en = r.pwr_a;
   assign power_b_en = r.pwr_b;
   assign channel_cut_current = r.cut;
   assign channel_limit_current = r.lim;
   assign port_cut_power = r.portpw;
   assign channel_cut_power = r.chpw;

endmodule

// [verilog/pmc_map.svh]
/*
 File holds the register offsets, field positions, reset values and timing
 figures of the port mode controller.
 Assumes it is included by its bare name into packages and modules.
*/
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH

`define PMC_OFF_CTRL 8'h00
`define PMC_OFF_CMD 8'h04
`define PMC_OFF_STAT 8'h08
`define PMC_OFF_CURR 8'h0c
`define PMC_OFF_POWER 8'h10

`define PMC_CTRL_MODE_LSB 0
`define PMC_CTRL_DET_EN 2
`define PMC_CTRL_CLS_EN 3
`define PMC_CTRL_DISC_EN 4
`define PMC_CTRL_FOUR_PAIR 5
`define PMC_CTRL_AT_MODE 6
`define PMC_CTRL_STRAP 7
`define PMC_CTRL_GLOBAL_RST 31

`define PMC_CMD_DET 0
`define PMC_CMD_DET_CLS 1
`define PMC_CMD_PWR_ON 2
`define PMC_CMD_PWR_OFF 3

`define PMC_STAT_DET_LSB 0
`define PMC_STAT_CLS_LSB 4
`define PMC_STAT_CONN_LSB 8
`define PMC_STAT_PWR_A 10
`define PMC_STAT_PWR_B 11
`define PMC_STAT_START_FAULT 12
`define PMC_STAT_STATE_LSB 16

`define PMC_MODE_OFF 2'h0
`define PMC_MODE_MANUAL 2'h1
`define PMC_MODE_SEMI 2'h2
`define PMC_MODE_AUTO 2'h3

`define PMC_RST_CTRL_FOUR_PAIR 1'h1
`define PMC_RST_CUT 16'h0000
`define PMC_RST_LIM 16'h0000
`define PMC_RST_CHPW 16'h0000
`define PMC_RST_PORTPW 16'h0000

`define PMC_RES_ACCEPT_LO 16'h4268
`define PMC_RES_ACCEPT_HI 16'h7148
`define PMC_MAX_CLASS_SINGLE 4'h8
`define PMC_MAX_CLASS_DUAL 4'h5

`define PMC_HOLD_MS 100
`define PMC_CLK_KHZ 200000

`define PMC_RESP_OKAY 2'h0
`define PMC_RESP_SLVERR 2'h2

`endif

// [verilog/pmc_pkg.sv]
/*
 File holds the types and the class threshold tables of the port mode
 controller.
 Assumes the map header sits on the include path.
*/
package pmc_pkg;
   `include "pmc_map.svh"

   typedef enum logic [2:0] {PMC_IDLE, PMC_CC, PMC_DET, PMC_CLS, PMC_WAIT, PMC_ON}
      pmc_state_type;

   // Detection result codes and connection results as seen in the status word.
   typedef enum logic [1:0] {DET_UNKNOWN, DET_GOOD, DET_LOW, DET_HIGH} pmc_det_type;
   typedef enum logic [1:0] {CONN_NONE, CONN_SINGLE, CONN_DUAL, CONN_INVALID} pmc_conn_type;

   // Currents are in mA, powers in units of 10 mW, indexed by assigned class.
   localparam logic [15:0] PMC_SS_CUT [1:8] = '{16'h005e, 16'h0096, 16'h0152, 16'h027e,
      16'h0245, 16'h02db, 16'h0339, 16'h03cf};
   localparam logic [15:0] PMC_SS_LIM [1:8] = '{16'h01a9, 16'h01a9, 16'h01a9, 16'h0352,
      16'h0352, 16'h0352, 16'h0427, 16'h048f};
   localparam logic [15:0] PMC_SS_PW [1:8] = '{16'h01e6, 16'h02f4, 16'h0654, 16'h0ca8,
      16'h12ca, 16'h191e, 16'h1f72, 16'h258a};
   localparam logic [15:0] PMC_DS_CUT [1:5] = '{16'h005e, 16'h0096, 16'h0152, 16'h027e,
      16'h03cf};
   localparam logic [15:0] PMC_DS_LIM [1:5] = '{16'h01a9, 16'h01a9, 16'h01a9, 16'h0352,
      16'h048f};
   localparam logic [15:0] PMC_DS_PW [1:5] = '{16'h01e6, 16'h02f4, 16'h0654, 16'h0ca8,
      16'h12ca};

   typedef struct packed {
      pmc_state_type state;
      logic [1:0] mode_act;
      logic cls_want;
      logic [1:0] ctrl_mode;
      logic det_en;
      logic cls_en;
      logic disc_en;
      logic four_pair;
      logic at_mode;
      logic strap;
      logic soft_rst;
      pmc_det_type det_res;
      logic [3:0] cls_res;
      pmc_conn_type conn;
      logic start_fault;
      logic pwr_a;
      logic pwr_b;
      logic cc_start;
      logic det_start;
      logic cls_start;
      logic [15:0] cut;
      logic [15:0] lim;
      logic [15:0] chpw;
      logic [15:0] portpw;
      logic [31:0] hold;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic have_aw;
      logic have_w;
      logic [7:0] waddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
   } pmc_regs_type;
endpackage

// [sim/pmc_port_ctrl_props.sv]
/* Checks on the port mode controller ports.
   Assumes it is bound into every pmc_port_ctrl. */
`timescale 1ns/1ps
module pmc_port_ctrl_props #(
   parameter logic [11:0] CC_MIN = 12'h004
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic cc_start,
   input wire logic cc_done,
   input wire logic cc_event,
   input wire logic [11:0] cc_i1,
   input wire logic det_start,
   input wire logic det_done,
   input wire logic [15:0] det_res_ohm,
   input wire logic cls_start,
   input wire logic cls_done,
   input wire logic [3:0] cls_result,
   input wire logic [1:0] fault_in,
   input wire logic power_a_en,
   input wire logic power_b_en,
   input wire logic [15:0] channel_cut_current
);
   default clocking dc @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence cc_ok;
      cc_done && !cc_event && cc_i1 >= CC_MIN;
   endsequence
   sequence cc_bad;
      cc_done && cc_event;
   endsequence
   sequence det_bad;
      det_done && (det_res_ohm < 16'h3a98 || det_res_ohm > 16'h80e8);
   endsequence
   a_fault_a_off: assert property (fault_in[0] |=> !power_a_en)
      else $error("A on after fault");
   a_fault_b_off: assert property (fault_in[1] |=> !power_b_en)
      else $error("B on after fault");
   a_reset_clean: assert property ($rose(aresetn) |->
      !(power_a_en || power_b_en || cc_start || det_start) && channel_cut_current == '0)
      else $error("not clean after reset");
   a_start_pulse: assert property (det_start |=> !det_start)
      else $error("detect start too long");
   a_check_det: assert property (cc_ok |=> det_start)
      else $error("no detect after check");
   a_check_inval: assert property (cc_bad |=> !det_start ##1 !det_start)
      else $error("detect after invalid check");
   a_reject_nocls: assert property (det_bad |=> !cls_start)
      else $error("class after rejected detect");
   a_class_range: assert property (
      cls_done && (cls_result == 4'h0 || cls_result > 4'h8) |=> !$rose(power_a_en))
      else $error("power on bad class");
endmodule

bind pmc_port_ctrl pmc_port_ctrl_props #(.CC_MIN(CC_MIN)) u_props (.aclk, .aresetn,
   .cc_start, .cc_done, .cc_event, .cc_i1, .det_start, .det_done, .det_res_ohm,
   .cls_start, .cls_done, .cls_result, .fault_in, .power_a_en, .power_b_en,
   .channel_cut_current);

// [sim/pmc_front_model.sv]
/* Analog front end model: each start pulse gets one done pulse.
   Assumes the bench sets the values it measures. */
`timescale 1ns/1ps
module pmc_front_model (
   input wire logic aclk,
   input wire logic cc_start,
   input wire logic det_start,
   input wire logic cls_start,
   input wire logic dual,
   input wire logic ev,
   input wire logic [15:0] res,
   input wire logic [3:0] cls,
   output logic cc_done,
   output logic cc_event,
   output logic [11:0] cc_i1,
   output logic [11:0] cc_i2,
   output logic det_done,
   output logic [15:0] det_res_ohm,
   output logic cls_done,
   output logic [3:0] cls_result
);
   // Answers alternate between quick and slow.
   logic [2:0] wait_reg = '0;
   logic [1:0] kind_reg = '0;
   logic slow_reg = '0;
   logic fire;
   assign fire = wait_reg == 3'h1;
   initial begin
      {cc_done, det_done, cls_done, cc_event, cc_i1, cc_i2, det_res_ohm, cls_result} = '0;
   end
   always @(posedge aclk) begin
      cc_done <= fire && kind_reg == 2'h1;
      det_done <= fire && kind_reg == 2'h2;
      cls_done <= fire && kind_reg == 2'h3;
      // Data lines hold no result outside done, so they toggle.
      cc_event <= fire ? ev : ~cc_event;
      cc_i1 <= fire ? (dual ? 12'h100 : 12'h200) : ~cc_i1;
      cc_i2 <= fire ? 12'h100 : ~cc_i2;
      det_res_ohm <= fire ? res : ~det_res_ohm;
      cls_result <= fire ? cls : ~cls_result;
      if (cc_start || det_start || cls_start) begin
         kind_reg <= cc_start ? 2'h1 : (det_start ? 2'h2 : 2'h3);
         wait_reg <= slow_reg ? 3'h5 : 3'h1;
         slow_reg <= ~slow_reg;
      end else if (wait_reg != '0) begin
         wait_reg <= wait_reg - 3'h1;
      end
   end
endmodule

// [sim/tb.sv]
/* Bench: AXI4-Lite host tasks and mode scenarios.
   Assumes the front end model and checker are compiled first. */
`timescale 1ns/1ps
module tb;
   logic aclk = '0, aresetn = '0, auto_strap_pin = '0, s_axi_awvalid = '0, s_axi_wvalid = '0;
   logic s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0, fe_dual = '0, fe_ev = '0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic cc_start, cc_done, cc_event, det_start, det_done, cls_start, cls_done;
   logic power_a_en, power_b_en;
   logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, v;
   logic [3:0] s_axi_wstrb = 4'hf, cls_result, fe_cls = '0;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp, fault_in = '0, disc_in = '0;
   logic [11:0] cc_i1, cc_i2;
   logic [15:0] det_res_ohm, fe_res = 16'h61a8, channel_cut_current, channel_limit_current;
   logic [15:0] port_cut_power, channel_cut_power;
   int mismatches = 0, n_tests = 0, n_det = 0, n_cc = 0, d0;
   always #2.5 aclk = ~aclk;
   pmc_port_ctrl #(.HOLD_CYCLES(8)) DUT (.aclk, .aresetn, .auto_strap_pin, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cc_start, .cc_done, .cc_event,
      .cc_i1, .cc_i2, .det_start, .det_done, .det_res_ohm, .cls_start, .cls_done, .cls_result,
      .fault_in, .disc_in, .power_a_en, .power_b_en, .channel_cut_current,
      .channel_limit_current, .port_cut_power, .channel_cut_power);
   pmc_front_model FE (.aclk, .cc_start, .det_start, .cls_start, .dual(fe_dual), .ev(fe_ev),
      .res(fe_res), .cls(fe_cls), .cc_done, .cc_event, .cc_i1, .cc_i2, .det_done, .det_res_ohm,
      .cls_done, .cls_result);
   always @(posedge aclk) begin
      n_det <= n_det + int'(det_start);
      n_cc <= n_cc + int'(cc_start);
   end
   task automatic chk(input logic [31:0] s, e);
      n_tests++;
      if (s !== e) begin
         mismatches++;
         $display("[FAIL] %0t seen %h exp %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= '0;
         if (s_axi_wready) s_axi_wvalid <= '0;
      end while (!s_axi_bvalid);
      s_axi_bready <= '0;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= '0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= '0;
      @(posedge aclk);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] m, e);
      logic [31:0] r;
      rd(a, r);
      chk(r & m, e);
   endtask
   task automatic wst(input logic [2:0] s);
      logic [31:0] r;
      for (int i = 0; i < 100; i++) begin
         rd(8'h08, r);
         if (r[18:16] === s) break;
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic pw(input logic [1:0] e);
      chk({30'h0, power_b_en, power_a_en}, {30'h0, e});
   endtask
   task automatic rst;
      aresetn <= '0;
      cyc(4);
      aresetn <= 1'h1;
   endtask
   task automatic fin(input string s);
      $display("test %s done", s);
   endtask
   task automatic conclude;
      $display("compares %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      rst;
      rc(8'h00, '1, 32'h20);
      rc(8'h0c, '1, '0);
      rd(8'h14, v);
      chk({30'h0, rsp}, 32'h2);
      fin("reset");
      wr(8'h00, 32'h21);
      wr(8'h04, 32'h2);
      wst(3'h0);
      rc(8'h08, 32'h3ff, 32'h101);
      rc(8'h0c, '1, '0);
      wr(8'h04, 32'h4);
      pw(2'h3);
      fault_in <= 2'h1;
      cyc(2);
      pw(2'h0);
      fault_in <= '0;
      fe_res <= 16'h9c40;
      wr(8'h04, 32'h1);
      wst(3'h0);
      wr(8'h04, 32'h4);
      rc(8'h08, 32'h1c03, 32'h1003);
      wr(8'h08, 32'h1000);
      fin("manual");
      d0 = n_det;
      wr(8'h00, 32'h2c);
      wr(8'h04, 32'h6);
      cyc(20);
      chk(32'(n_det - d0), '0);
      pw(2'h0);
      fin("shutdown");
      fe_res <= 16'h61a8;
      fe_cls <= 4'h8;
      wr(8'h00, 32'h3f);
      wst(3'h5);
      pw(2'h3);
      rc(8'h0c, '1, 32'h048f03cf);
      rc(8'h10, 32'hffff, 32'h258a);
      fe_dual <= 1'h1;
      fe_cls <= 4'h5;
      disc_in <= 2'h1;
      cyc(2);
      pw(2'h0);
      disc_in <= '0;
      wst(3'h5);
      rc(8'h08, 32'h300, 32'h200);
      rc(8'h0c, '1, 32'h048f03cf);
      rc(8'h10, '1, 32'h12ca2594);
      fault_in <= 2'h2;
      cyc(2);
      pw(2'h1);
      rc(8'h10, 32'hffff, 32'h12ca);
      fault_in <= '0;
      wr(8'h00, 32'h20);
      pw(2'h0);
      fin("auto");
      fe_ev <= 1'h1;
      d0 = n_det;
      wr(8'h00, 32'h3f);
      wst(3'h4);
      rc(8'h08, 32'h300, 32'h300);
      chk(32'(n_det - d0), '0);
      wr(8'h00, '0);
      fe_ev <= '0;
      wr(8'h00, 32'h1f);
      d0 = n_cc;
      wst(3'h5);
      chk(32'(n_cc - d0), '0);
      rc(8'h08, 32'h300, 32'h100);
      fin("check");
      fe_dual <= '0;
      wr(8'h00, 32'h20);
      d0 = n_det - n_cc;
      wr(8'h00, 32'h6e);
      cyc(80);
      chk(32'(n_det - n_cc - d0 >= 2), 32'h1);
      pw(2'h0);
      wst(3'h4);
      wr(8'h04, 32'h4);
      pw(2'h3);
      fin("semi");
      auto_strap_pin <= 1'h1;
      rst;
      rc(8'h00, 32'hff, 32'hbf);
      auto_strap_pin <= '0;
      wst(3'h5);
      pw(2'h3);
      rc(8'h00, 32'hff, 32'hbf);
      wr(8'h00, 32'h80000000);
      rc(8'h00, 32'hff, 32'h20);
      pw(2'h0);
      fin("strap");
      conclude;
   end
   initial begin
      #200us;
      mismatches++;
      conclude;
   end
endmodule
